// File: hdl/iwd_decoder.sv
// Instruction word decoder with four-phase instruction cycle timing.
`timescale 1ns/10ps
// Functional notes
// - Base set of 75 instructions plus 8 extended ones, gated by ext_en.
// - A single-word instruction is one 16-bit word: opcode plus operands.
// - Four instructions take two words, giving 32 bits of information.
// - Second words start with 1111; executed alone they act as no-operation.
// - Byte operations carry file selector, destination and access selector.
// - Destination zero targets working register; one targets the file register.
// - Bit operations carry file selector, access selector and bit number.
// - Literal operations carry a constant, a pointer selector, or nothing.
// - Control operations carry address, call mode, table mode, or nothing.
// - Single word takes one cycle; true test or PC change adds one NOP cycle.
// - Two-word instructions always take two instruction cycles.
// - One instruction cycle is four consecutive oscillator periods.
module iwd_decoder
  import iwd_pkg::*;
(
  input wire logic ref_clk, // Oscillator clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic [15:0] mem_word, // Program word, valid in the last phase.
  input wire logic ext_en, // Enables the extended instruction group.
  input wire logic cond_true, // Outcome of the pending conditional test.
  output logic fetch_strobe_reg, // Pulse: fetch the next program word.
  output logic [1:0] q_phase_reg, // Current oscillator phase of the cycle.
  output logic instr_strobe_reg, // Pulse: new instruction decoded.
  output logic [1:0] instr_cycles_reg, // Cycles of the decoded instruction.
  output logic nop_cycle_reg, // Pulse: the cycle just taken runs as NOP.
  output logic operand_done_reg, // Pulse: second word merged into prog_addr.
  output iwd_dec_t dec_reg // Decoded fields of the instruction.
);

  // ****************************************
  // Phase counter
  // ****************************************
  logic tick;
  logic take_new;
  iwd_state_t state_reg;
  iwd_dec_t wd;

  // The phase counter divides the oscillator into four-period cycles.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_phase_reg <= IWD_Q_RESET;
    end else if (clk_en) begin
      q_phase_reg <= q_phase_reg + 2'h1;
    end
  end

  // Work on a word happens only in the last phase of each cycle.
  assign tick = clk_en && (q_phase_reg == IWD_Q_LAST);
  assign take_new = tick && ((state_reg == ST_DECODE) || ((state_reg == ST_COND) && !cond_true));

  // The fetch request is set from the first phase and stands in the second phase of each cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_strobe_reg <= 1'b0;
    end else if (clk_en) begin
      fetch_strobe_reg <= (q_phase_reg == IWD_Q_FIRST);
    end
  end

  // ****************************************
  // Word decode
  // ****************************************
  // Splits the word into its class and operand fields.
  always_comb begin
    logic [3:0] opc;
    logic [3:0] sub;
    opc = mem_word[IWD_OPC_HI:IWD_OPC_LO];
    sub = mem_word[IWD_SUB_HI:IWD_SUB_LO];
    wd = IWD_DEC_RESET;
    wd.file_sel = mem_word[IWD_F_HI:0];
    wd.access_sel = mem_word[IWD_A_POS];
    wd.literal = mem_word[IWD_F_HI:0];
    if (opc == IWD_OPC_MISC) begin
      wd.cat = CAT_CTRL;
      if (mem_word[IWD_F_HI:0] >= IWD_MISC_TBL_LO && mem_word[IWD_F_HI:0] <= IWD_MISC_TBL_HI) begin
        wd.tbl_mode = mem_word[1:0];
      end
      if (mem_word[IWD_F_HI:0] >= IWD_MISC_RET_LO && mem_word[IWD_F_HI:0] <= IWD_MISC_RET_HI) begin
        wd.call_mode = mem_word[0];
        wd.pc_change = 1'b1;
      end
      if (mem_word[IWD_F_HI:0] == 8'h00) begin
        wd.cat = CAT_NOP;
      end
    end else if (opc >= IWD_OPC_BYTE_LO && opc <= IWD_OPC_BYTE_HI) begin
      wd.cat = CAT_BYTE;
      wd.to_file = mem_word[IWD_D_POS];
      wd.to_working = !mem_word[IWD_D_POS];
    end else if (opc >= IWD_OPC_BIT_LO && opc <= IWD_OPC_BIT_HI) begin
      wd.cat = CAT_BIT;
      wd.bit_num = mem_word[IWD_B_HI:IWD_B_LO];
    end else if (opc == IWD_OPC_MOVFF) begin
      wd.cat = CAT_BYTE;
      wd.to_file = 1'b1;
      wd.two_word = 1'b1;
      wd.prog_addr = {8'h00, mem_word[IWD_SEC_LO_HI:0]};
    end else if (opc == IWD_OPC_BRA) begin
      wd.cat = CAT_CTRL;
      wd.prog_addr = {9'h000, mem_word[IWD_N_HI:0]};
      wd.pc_change = 1'b1;
    end else if (opc == IWD_OPC_EXT) begin
      if (sub <= IWD_SUB_LIT_MAX) begin
        wd.cat = CAT_LIT;
      end else if (sub == IWD_SUB_EXTGRP) begin
        wd.cat = ext_en ? CAT_EXT : CAT_NOP;
        wd.ext_idx = mem_word[IWD_EXT_HI:IWD_EXT_LO];
      end else if (sub == IWD_SUB_CBRANCH) begin
        wd.cat = CAT_CTRL;
        wd.prog_addr = {12'h000, mem_word[IWD_F_HI:0]};
        wd.cond = 1'b1;
      end else if (sub == IWD_SUB_CALL || sub == IWD_SUB_GOTO) begin
        wd.cat = CAT_CTRL;
        wd.call_mode = mem_word[IWD_A_POS];
        wd.prog_addr = {12'h000, mem_word[IWD_F_HI:0]};
        wd.two_word = 1'b1;
        wd.pc_change = 1'b1;
      end else if (sub == IWD_SUB_LFSR) begin
        wd.cat = CAT_LIT;
        wd.fsr_sel = mem_word[IWD_FSR_HI:IWD_FSR_LO];
        wd.prog_addr = {16'h0000, mem_word[3:0]};
        wd.two_word = 1'b1;
      end else begin
        wd.cat = CAT_NOP;
      end
    end else begin
      wd.cat = CAT_NOP;
    end
  end

  // ****************************************
  // Cycle sequencing
  // ****************************************
  // Chooses the role of the word taken at the end of each cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_DECODE;
    end else if (take_new) begin
      if (wd.two_word) begin
        state_reg <= ST_SECOND;
      end else if (wd.cond) begin
        state_reg <= ST_COND;
      end else if (wd.pc_change) begin
        state_reg <= ST_FLUSH;
      end else begin
        state_reg <= ST_DECODE;
      end
    end else if (tick) begin
      state_reg <= ST_DECODE;
    end
  end

  // Latches decoded fields and merges the second word into the address.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dec_reg <= IWD_DEC_RESET;
    end else if (take_new) begin
      dec_reg <= wd;
    end else if (tick && state_reg == ST_SECOND) begin
      dec_reg.prog_addr <= {mem_word[IWD_SEC_LO_HI:0], dec_reg.prog_addr[7:0]};
    end
  end

  // Strobes and the cycle count of each new instruction.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instr_strobe_reg <= 1'b0;
      instr_cycles_reg <= 2'h0;
      operand_done_reg <= 1'b0;
    end else if (clk_en) begin
      instr_strobe_reg <= take_new;
      operand_done_reg <= tick && (state_reg == ST_SECOND);
      if (take_new) begin
        instr_cycles_reg <= (wd.two_word || wd.pc_change) ? 2'h2 : 2'h1;
      end
    end
  end

  // Flags the cycles that execute as no-operation.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nop_cycle_reg <= 1'b0;
    end else if (clk_en) begin
      if (tick && state_reg != ST_DECODE && !take_new) begin
        nop_cycle_reg <= 1'b1;
      end else if (take_new && wd.cat == CAT_NOP) begin
        nop_cycle_reg <= 1'b1;
      end else begin
        nop_cycle_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && q_phase_reg == IWD_Q_LAST) |=> (q_phase_reg == IWD_Q_FIRST))
    else $error("Phase counter did not wrap after the fourth phase.");

  // A strobe may only stand for longer than one edge while the enable holds it frozen.
  a_strobe_phase: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_strobe_reg |->
      (q_phase_reg == IWD_Q_FIRST) && (!$past(instr_strobe_reg) || !$past(clk_en)))
    else $error("Instruction strobe outside the first phase.");

  // The fetch request stands in the second phase of every cycle.
  a_fetch_phase: assert property (@(posedge ref_clk) disable iff (!rstn)
    fetch_strobe_reg |-> (q_phase_reg == IWD_Q_FIRST + 2'h1))
    else $error("Fetch request outside the second phase.");

  a_second_nop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && mem_word[15:12] == IWD_OPC_SECOND) |=> nop_cycle_reg && dec_reg.cat == CAT_NOP)
    else $error("Lone second word did not decode as no-operation.");

  a_two_word_len: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.two_word) |=> (instr_cycles_reg == 2'h2) && (state_reg == ST_SECOND))
    else $error("Two-word instruction not given two cycles.");

  a_second_merge: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tick && state_reg == ST_SECOND) |=>
      operand_done_reg && dec_reg.prog_addr[19:8] == $past(mem_word[11:0]) && nop_cycle_reg)
    else $error("Second word not merged into the operand.");

  a_dest_select: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.cat == CAT_BYTE && !wd.two_word) |=>
      (dec_reg.to_working == !$past(mem_word[9])) && (dec_reg.to_file == $past(mem_word[9])))
    else $error("Destination selector decoded the wrong way.");

  // A single-word jump counts two cycles and arms the flush of the word already fetched.
  a_jump_flush: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.pc_change && !wd.two_word) |=>
      (instr_cycles_reg == 2'h2) && (state_reg == ST_FLUSH))
    else $error("Program counter change did not add a flush cycle.");

  // The flushed cycle runs as a no-operation and starts no new instruction.
  a_flush_nop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tick && state_reg == ST_FLUSH) |=> nop_cycle_reg && !instr_strobe_reg)
    else $error("Flush cycle did not run as a no-operation.");

  a_cond_skip: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tick && state_reg == ST_COND && cond_true) |=> nop_cycle_reg && !instr_strobe_reg)
    else $error("True conditional test did not insert a no-operation cycle.");

  // Only the first edge of a strobe sees the enable that came with its word.
  a_ext_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(instr_strobe_reg) && dec_reg.cat == CAT_EXT) |-> $past(ext_en))
    else $error("Extended instruction decoded while the group is disabled.");

  // Byte operations keep the file and access selectors of their word.
  a_byte_fields: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.cat == CAT_BYTE) |=>
      (dec_reg.file_sel == $past(mem_word[7:0])) && (dec_reg.access_sel == $past(mem_word[8])))
    else $error("Byte operation fields decoded wrongly.");

  // Bit operations keep the bit number of their word.
  a_bit_fields: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.cat == CAT_BIT) |=> (dec_reg.bit_num == $past(mem_word[11:9])))
    else $error("Bit number decoded wrongly.");

  // Literal operations keep the constant of their word.
  a_lit_fields: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && wd.cat == CAT_LIT) |=> (dec_reg.literal == $past(mem_word[7:0])))
    else $error("Literal constant decoded wrongly.");

  a_single_len: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take_new && !wd.two_word && !wd.pc_change) |=> instr_cycles_reg == 2'h1)
    else $error("Single-word instruction not counted as one cycle.");

  // Main scenarios that the tests are expected to reach.
  c_two_word: cover property (@(posedge ref_clk) disable iff (!rstn)
    (tick && state_reg == ST_SECOND) ##1 operand_done_reg);

  c_flush: cover property (@(posedge ref_clk) disable iff (!rstn)
    tick && state_reg == ST_FLUSH);

  c_cond_true: cover property (@(posedge ref_clk) disable iff (!rstn)
    tick && state_reg == ST_COND && cond_true);

  c_bit_op: cover property (@(posedge ref_clk) disable iff (!rstn)
    instr_strobe_reg && dec_reg.cat == CAT_BIT);

  c_ext_op: cover property (@(posedge ref_clk) disable iff (!rstn)
    instr_strobe_reg && dec_reg.cat == CAT_EXT);

endmodule

// File: hdl/iwd_pkg.sv
// Package with the decoder's field layout, opcode classes, states and counts.
package iwd_pkg;

  // ****************************************
  // Instruction set sizes and timing
  // ****************************************
  localparam int unsigned IWD_BASE_COUNT = 75;
  localparam int unsigned IWD_EXT_COUNT = 8;
  localparam int unsigned IWD_OSC_PER_CYCLE = 4;
  localparam logic [1:0] IWD_Q_LAST = 2'h3;
  localparam logic [1:0] IWD_Q_FIRST = 2'h0;
  localparam logic [1:0] IWD_Q_RESET = 2'h0;

  // ****************************************
  // Field positions within a program word
  // ****************************************
  localparam int unsigned IWD_WORD_W = 16;
  localparam int unsigned IWD_OPC_HI = 15;
  localparam int unsigned IWD_OPC_LO = 12;
  localparam int unsigned IWD_SUB_HI = 11;
  localparam int unsigned IWD_SUB_LO = 8;
  localparam int unsigned IWD_F_HI = 7;
  localparam int unsigned IWD_A_POS = 8;
  localparam int unsigned IWD_D_POS = 9;
  localparam int unsigned IWD_B_HI = 11;
  localparam int unsigned IWD_B_LO = 9;
  localparam int unsigned IWD_FSR_HI = 5;
  localparam int unsigned IWD_FSR_LO = 4;
  localparam int unsigned IWD_N_HI = 10;
  localparam int unsigned IWD_EXT_HI = 7;
  localparam int unsigned IWD_EXT_LO = 5;
  localparam int unsigned IWD_SEC_LO_HI = 11;

  // ****************************************
  // Opcode class values
  // ****************************************
  localparam logic [3:0] IWD_OPC_MISC = 4'h0;
  localparam logic [3:0] IWD_OPC_BYTE_LO = 4'h1;
  localparam logic [3:0] IWD_OPC_BYTE_HI = 4'h6;
  localparam logic [3:0] IWD_OPC_BIT_LO = 4'h7;
  localparam logic [3:0] IWD_OPC_BIT_HI = 4'hB;
  localparam logic [3:0] IWD_OPC_MOVFF = 4'hC;
  localparam logic [3:0] IWD_OPC_BRA = 4'hD;
  localparam logic [3:0] IWD_OPC_EXT = 4'hE;
  localparam logic [3:0] IWD_OPC_SECOND = 4'hF;
  localparam logic [3:0] IWD_SUB_LIT_MAX = 4'h7;
  localparam logic [3:0] IWD_SUB_EXTGRP = 4'h8;
  localparam logic [3:0] IWD_SUB_CBRANCH = 4'h9;
  localparam logic [3:0] IWD_SUB_CALL = 4'hC;
  localparam logic [3:0] IWD_SUB_LFSR = 4'hE;
  localparam logic [3:0] IWD_SUB_GOTO = 4'hF;
  localparam logic [7:0] IWD_MISC_TBL_LO = 8'h08;
  localparam logic [7:0] IWD_MISC_TBL_HI = 8'h0F;
  localparam logic [7:0] IWD_MISC_RET_LO = 8'h10;
  localparam logic [7:0] IWD_MISC_RET_HI = 8'h13;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CAT_NOP = 3'b000,
    CAT_BYTE = 3'b001,
    CAT_BIT = 3'b010,
    CAT_LIT = 3'b011,
    CAT_CTRL = 3'b100,
    CAT_EXT = 3'b101
  } iwd_cat_t;

  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_SECOND = 2'b01,
    ST_COND = 2'b10,
    ST_FLUSH = 2'b11
  } iwd_state_t;

  typedef struct packed {
    iwd_cat_t cat;
    logic [7:0] file_sel;
    logic to_working;
    logic to_file;
    logic access_sel;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic [1:0] fsr_sel;
    logic [19:0] prog_addr;
    logic call_mode;
    logic [1:0] tbl_mode;
    logic [2:0] ext_idx;
    logic two_word;
    logic pc_change;
    logic cond;
  } iwd_dec_t;

  localparam iwd_dec_t IWD_DEC_RESET = '0;

endpackage

// File: sim/iwd_prog_mem.sv
// Program memory model feeding the decoder.
`timescale 1ns/10ps
module iwd_prog_mem
  import iwd_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic clk_en, // Clock enable.
  input wire logic fetch_strobe_reg, // Fetch request.
  input wire logic [1:0] q_phase_reg, // Phase.
  output logic [15:0] mem_word, // Word.
  output logic cond_true, // Test outcome.
  output logic ext_en // Extended enable.
);
  logic [17:0] mem_arr [0:255];
  logic [7:0] ptr_reg;

  // A fetch shows the next word; once taken the lines show its inverse.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= 8'h00;
      {ext_en, cond_true, mem_word} <= 18'h3_ffff;
    end else if (clk_en && fetch_strobe_reg) begin
      {ext_en, cond_true, mem_word} <= mem_arr[ptr_reg];
      ptr_reg <= ptr_reg + 8'h01;
    end else if (clk_en && q_phase_reg == 2'h3) begin
      {ext_en, cond_true, mem_word} <= ~{ext_en, cond_true, mem_word};
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking testbench for the instruction word decoder.
`timescale 1ns/10ps
module tb_top
  import iwd_pkg::*;
;
  typedef struct packed {
    logic [2:0] fl;
    logic [1:0] cy;
    logic [3:0] k;
    logic [15:0] w;
  } iwd_note_t;
  logic ref_clk = 0;
  logic rstn = 0;
  logic clk_en = 1;
  logic en_q = 0;
  logic [15:0] mem_word;
  logic ext_en, cond_true, fetch_strobe_reg, instr_strobe_reg, nop_cycle_reg, operand_done_reg;
  logic [1:0] q_phase_reg, instr_cycles_reg;
  iwd_dec_t dec_reg;
  iwd_note_t exp_q[$];
  logic [31:0] r = 32'h0000_281d;
  int n_fail = 0;
  int num_checks = 0;
  int nw = 0;
  int gap = 0;
  int seen = 0;

  iwd_decoder i_iwd_decoder (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .mem_word(mem_word), .ext_en(ext_en), .cond_true(cond_true),
    .fetch_strobe_reg(fetch_strobe_reg), .q_phase_reg(q_phase_reg),
    .instr_strobe_reg(instr_strobe_reg), .instr_cycles_reg(instr_cycles_reg),
    .nop_cycle_reg(nop_cycle_reg), .operand_done_reg(operand_done_reg), .dec_reg(dec_reg));
  iwd_prog_mem i_iwd_prog_mem (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .fetch_strobe_reg(fetch_strobe_reg), .q_phase_reg(q_phase_reg),
    .mem_word(mem_word), .cond_true(cond_true), .ext_en(ext_en));

  // Clock generator.
  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Store a word with its side inputs and note the result it must give.
  task automatic put(input logic [15:0] w, input logic c, input logic x, input logic [2:0] fl,
                     input logic [1:0] cy, input logic [3:0] k);
    i_iwd_prog_mem.mem_arr[nw] = {x, c, w};
    nw++;
    exp_q.push_back(iwd_note_t'{fl, cy, k, w});
  endtask

  task automatic two(input logic [15:0] w1, input logic [3:0] k, input logic [15:0] w2);
    put(w1, 1'b0, 1'b0, 3'b100, 2'h2, k);
    put(w2, 1'b0, 1'b0, 3'b011, 2'h0, 4'hC);
  endtask

  // Random clock-enable stalls after reset.
  always @(negedge ref_clk) begin
    if (rstn) begin
      r = lfsr(r);
      clk_en = (r[2:0] != 3'h0);
    end
  end

  always @(posedge ref_clk) en_q <= clk_en & rstn;

  // Watch the outputs and compare each result with the oldest note.
  always @(negedge ref_clk) begin
    iwd_note_t nt;
    iwd_dec_t d;
    logic [31:0] got, ex;
    logic [2:0] fo;
    logic [1:0] co;
    if (en_q) gap++;
    if (en_q && fetch_strobe_reg) begin
      if (seen != 0) chk(gap, 4);
      gap = 0;
      seen = 1;
    end
    if (en_q && (instr_strobe_reg | nop_cycle_reg | operand_done_reg)) begin
      if (exp_q.size() == 0) chk(1, 0);
      else begin
        nt = exp_q.pop_front();
        d = dec_reg;
        got = 0;
        ex = 0;
        case (nt.k)
          0: begin
            got = {d.cat, d.file_sel, d.access_sel, d.to_file, d.to_working};
            ex = {CAT_BYTE, nt.w[7:0], nt.w[8], nt.w[9], !nt.w[9]};
          end
          1: begin
            got = {d.cat, d.file_sel, d.access_sel, d.bit_num};
            ex = {CAT_BIT, nt.w[7:0], nt.w[8], nt.w[11:9]};
          end
          2: begin got = {d.cat, d.literal}; ex = {CAT_LIT, nt.w[7:0]}; end
          3: begin got = {d.cat, d.ext_idx}; ex = {CAT_EXT, nt.w[7:5]}; end
          4: begin got = d.cat; ex = CAT_NOP; end
          5: begin got = {d.cat, d.tbl_mode}; ex = {CAT_CTRL, nt.w[1:0]}; end
          6: begin got = {d.cat, d.call_mode, d.pc_change}; ex = {CAT_CTRL, nt.w[0], 1'b1}; end
          7: begin got = {d.cat, d.pc_change}; ex = {CAT_CTRL, 1'b1}; end
          8: begin got = {d.cat, d.cond}; ex = {CAT_CTRL, 1'b1}; end
          9: begin got = {d.cat, d.two_word, d.prog_addr[7:0]}; ex = {CAT_CTRL, 1'b1, nt.w[7:0]}; end
          10: begin got = {d.cat, d.two_word}; ex = {CAT_CTRL, 1'b1}; end
          11: begin got = {d.cat, d.two_word, d.fsr_sel}; ex = {CAT_LIT, 1'b1, nt.w[5:4]}; end
          12: begin got = d.prog_addr[19:8]; ex = nt.w[11:0]; end
          14: begin got = d.two_word; ex = 1; end
          default: got = 0;
        endcase
        fo = {instr_strobe_reg, nop_cycle_reg, operand_done_reg};
        co = (nt.cy == 0) ? 2'h0 : instr_cycles_reg;
        chk({q_phase_reg, fo, co, got}, {2'h0, nt.fl, nt.cy, ex});
      end
    end
  end

  // Build the program, release reset and wait for every note to be met.
  initial begin
    int i;
    for (i = 0; i < 256; i++) i_iwd_prog_mem.mem_arr[i] = 18'h0_0000;
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      put({4'(1 + i % 6), r[11:10], 1'(i), r[8:0]}, 0, 0, 3'b100, 1, 0);
    end
    for (i = 0; i < 5; i++) begin
      r = lfsr(r);
      put({4'(7 + i), r[11:0]}, 0, 0, 3'b100, 1, 1);
    end
    for (i = 0; i < 8; i++) put({8'hE0 + 8'(i), r[7:0] ^ 8'(i)}, 0, 0, 3'b100, 1, 2);
    for (i = 0; i < 8; i++) put({8'hE8, 3'(i), 5'h0A}, 0, 1, 3'b100, 1, 3);
    put(16'hE8E0, 0, 0, 3'b110, 1, 4);
    put(16'hF123, 0, 0, 3'b110, 1, 4);
    for (i = 0; i < 4; i++) put(16'h0008 + 16'(i), 0, 0, 3'b100, 1, 5);
    for (i = 0; i < 2; i++) begin
      put(16'h0010 + 16'(i), 0, 0, 3'b100, 2, 6);
      put(16'h1234, 0, 0, 3'b010, 0, 15);
    end
    put(16'hD123, 0, 0, 3'b100, 2, 7);
    put(16'h1234, 0, 0, 3'b010, 0, 15);
    put(16'hE905, 0, 0, 3'b100, 1, 8);
    put(16'h1111, 1, 0, 3'b010, 0, 15);
    put(16'hE905, 0, 0, 3'b100, 1, 8);
    put(16'h1311, 0, 0, 3'b100, 1, 0);
    two(16'hEF12, 9, 16'hF345);
    two(16'hEC7A, 10, 16'hF001);
    for (i = 0; i < 4; i++) two({8'hEE, 2'b00, 2'(i), 4'h5}, 11, 16'hF0AB);
    two(16'hC012, 14, 16'hF0FF);
    put(16'h1005, 0, 0, 3'b100, 1, 0);
    repeat (8) @(negedge ref_clk);
    rstn = 1;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge ref_clk);
    if (exp_q.size() > 0) chk(exp_q.size(), 0);
    summarize();
  end

  // Watchdog against a hang.
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule
